//--- rtl/gpio_edge_pkg.sv
package gpio_edge_pkg;

  localparam int unsigned PIN_COUNT  = 32;
  localparam int unsigned HALF_WIDTH = 16;
  localparam int unsigned ADDR_WIDTH = 16;

  // Word addresses of the register pairs; the low half serves pins 15..0.
  localparam logic [15:0] ADDR_DIR_LOW       = 16'h1c06;
  localparam logic [15:0] ADDR_DIR_HIGH      = 16'h1c07;
  localparam logic [15:0] ADDR_IN_LOW        = 16'h1c08;
  localparam logic [15:0] ADDR_IN_HIGH       = 16'h1c09;
  localparam logic [15:0] ADDR_OUT_LOW       = 16'h1c0a;
  localparam logic [15:0] ADDR_OUT_HIGH      = 16'h1c0b;
  localparam logic [15:0] ADDR_EDGE_LOW      = 16'h1c0c;
  localparam logic [15:0] ADDR_EDGE_HIGH     = 16'h1c0d;
  localparam logic [15:0] ADDR_IRQ_EN_LOW    = 16'h1c0e;
  localparam logic [15:0] ADDR_IRQ_EN_HIGH   = 16'h1c0f;
  localparam logic [15:0] ADDR_IRQ_FLAG_LOW  = 16'h1c10;
  localparam logic [15:0] ADDR_IRQ_FLAG_HIGH = 16'h1c11;

  // Pins 31..27 and 20..0 exist; the other positions are empty.
  localparam logic [31:0] PIN_IMPL_MASK = 32'hf81f_ffff;

  localparam logic [31:0] DIR_RESET       = 32'h0000_0000;
  localparam logic [31:0] OUT_RESET       = 32'h0000_0000;
  localparam logic [31:0] EDGE_RESET      = 32'h0000_0000;
  localparam logic [31:0] IRQ_EN_RESET    = 32'h0000_0000;
  localparam logic [31:0] IRQ_FLAG_RESET  = 32'h0000_0000;
  localparam logic [31:0] SYNC_RESET      = 32'h0000_0000;
  localparam logic [15:0] RDATA_RESET     = 16'h0000;

  // Edge-select encoding per pin.
  localparam logic EDGE_RISING  = 1'b0;
  localparam logic EDGE_FALLING = 1'b1;

endpackage

//--- rtl/gpio_edge_port.sv
`timescale 1ns/1ps
// Functional notes
// - Input pins read their sampled level.
// - Output pins read back the driven value.
// - Output data always stored, hidden on inputs.
// - Output pins driven from output data.
// - Low register pins 0-15, high 16-31.
// - Only pins 31-27 and 20-0 exist.
// - Edge select: 0 rising, 1 falling.
// - Edge detection only on enabled input pins.
// - Enable bit 1 makes pin interrupt source.
// - Selected edge sets sticky flag bit.
// - Writing one clears a flag bit.
// - Active-low request held while any flag set.
// - Edges detected on clock-synchronised pin samples.
// - Hardware reset restores defaults, all pins inputs.
// - Software reset leaves port state unchanged.
// - All pin interrupts share one request line.
module gpio_edge_port
  import gpio_edge_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire logic [ADDR_WIDTH-1:0] reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [HALF_WIDTH-1:0] reg_wdata,
  output      logic [HALF_WIDTH-1:0] reg_rdata,
  input  wire logic [PIN_COUNT-1:0]  pin_in,
  output      logic [PIN_COUNT-1:0]  pin_out,
  output      logic [PIN_COUNT-1:0]  pin_oe_n,
  output      logic                  irq_n
);

  logic [PIN_COUNT-1:0]  dir_reg;
  logic [PIN_COUNT-1:0]  out_reg;
  logic [PIN_COUNT-1:0]  edge_reg;
  logic [PIN_COUNT-1:0]  irq_en_reg;
  logic [PIN_COUNT-1:0]  irq_flag_reg;
  logic [PIN_COUNT-1:0]  irq_flag_next;
  logic [PIN_COUNT-1:0]  meta_reg;
  logic [PIN_COUNT-1:0]  sync_reg;
  logic [PIN_COUNT-1:0]  prev_reg;
  logic [PIN_COUNT-1:0]  edge_hit;
  logic [PIN_COUNT-1:0]  flag_clear;
  logic [PIN_COUNT-1:0]  in_level;
  logic [HALF_WIDTH-1:0] reg_rdata_next;
  logic                  irq_n_reg;

  // Replaces the half of a 32-bit register that the address selects.
  function automatic logic [PIN_COUNT-1:0] merge_half(
    input logic [PIN_COUNT-1:0]  cur,
    input logic [HALF_WIDTH-1:0] wdata,
    input logic                  high
  );
    logic [PIN_COUNT-1:0] res;
    res = cur;
    if (high) begin
      res[31:16] = wdata;
    end else begin
      res[15:0] = wdata;
    end
    return res & PIN_IMPL_MASK;
  endfunction

  // Places write data in the addressed half, zero elsewhere.
  function automatic logic [PIN_COUNT-1:0] spread_half(
    input logic [HALF_WIDTH-1:0] wdata,
    input logic                  high
  );
    logic [PIN_COUNT-1:0] res;
    res = '0;
    if (high) begin
      res[31:16] = wdata;
    end else begin
      res[15:0] = wdata;
    end
    return res & PIN_IMPL_MASK;
  endfunction

  // The only reset input is the hardware reset; software resets of the
  // chip do not reach this block, so port state survives them.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dir_reg <= DIR_RESET;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == ADDR_DIR_LOW) begin
        dir_reg <= merge_half(dir_reg, reg_wdata, 1'b0);
      end else if (reg_addr == ADDR_DIR_HIGH) begin
        dir_reg <= merge_half(dir_reg, reg_wdata, 1'b1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_reg <= OUT_RESET;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == ADDR_OUT_LOW) begin
        out_reg <= merge_half(out_reg, reg_wdata, 1'b0);
      end else if (reg_addr == ADDR_OUT_HIGH) begin
        out_reg <= merge_half(out_reg, reg_wdata, 1'b1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      edge_reg <= EDGE_RESET;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == ADDR_EDGE_LOW) begin
        edge_reg <= merge_half(edge_reg, reg_wdata, 1'b0);
      end else if (reg_addr == ADDR_EDGE_HIGH) begin
        edge_reg <= merge_half(edge_reg, reg_wdata, 1'b1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_en_reg <= IRQ_EN_RESET;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == ADDR_IRQ_EN_LOW) begin
        irq_en_reg <= merge_half(irq_en_reg, reg_wdata, 1'b0);
      end else if (reg_addr == ADDR_IRQ_EN_HIGH) begin
        irq_en_reg <= merge_half(irq_en_reg, reg_wdata, 1'b1);
      end
    end
  end

  // Two-stage synchroniser, then one more stage as the edge reference.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_reg <= SYNC_RESET;
      sync_reg <= SYNC_RESET;
      prev_reg <= SYNC_RESET;
    end else if (clk_en) begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      if (PIN_IMPL_MASK[g]) begin : g_impl
        // Disabled or output pins never detect; otherwise the chosen edge counts.
        assign edge_hit[g] = (irq_en_reg[g] & ~dir_reg[g]) &
                             ((edge_reg[g] == EDGE_RISING) ?
                              (sync_reg[g] & ~prev_reg[g]) :
                              (~sync_reg[g] & prev_reg[g]));
        assign in_level[g] = dir_reg[g] ? out_reg[g] : sync_reg[g];
        assign pin_out[g]  = dir_reg[g] & out_reg[g];
        assign pin_oe_n[g] = ~dir_reg[g];
      end else begin : g_empty
        assign edge_hit[g] = 1'b0;
        assign in_level[g] = 1'b0;
        assign pin_out[g]  = 1'b0;
        assign pin_oe_n[g] = 1'b1;
      end
    end
  endgenerate

  always_comb begin
    flag_clear = '0;
    if (clk_en && reg_wr) begin
      if (reg_addr == ADDR_IRQ_FLAG_LOW) begin
        flag_clear = spread_half(reg_wdata, 1'b0);
      end else if (reg_addr == ADDR_IRQ_FLAG_HIGH) begin
        flag_clear = spread_half(reg_wdata, 1'b1);
      end
    end
  end

  // A new edge in the clearing cycle wins, so no event is lost.
  assign irq_flag_next = ((irq_flag_reg & ~flag_clear) | edge_hit) & PIN_IMPL_MASK;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_flag_reg <= IRQ_FLAG_RESET;
    end else if (clk_en) begin
      irq_flag_reg <= irq_flag_next;
    end
  end

  // One shared request; software scans both flag halves to find the pins.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_n_reg <= 1'b1;
    end else if (clk_en) begin
      irq_n_reg <= ~(|irq_flag_next);
    end
  end

  assign irq_n = irq_n_reg;

  always_comb begin
    if (reg_addr == ADDR_DIR_LOW) begin
      reg_rdata_next = dir_reg[15:0];
    end else if (reg_addr == ADDR_DIR_HIGH) begin
      reg_rdata_next = dir_reg[31:16];
    end else if (reg_addr == ADDR_IN_LOW) begin
      reg_rdata_next = in_level[15:0];
    end else if (reg_addr == ADDR_IN_HIGH) begin
      reg_rdata_next = in_level[31:16];
    end else if (reg_addr == ADDR_OUT_LOW) begin
      reg_rdata_next = out_reg[15:0];
    end else if (reg_addr == ADDR_OUT_HIGH) begin
      reg_rdata_next = out_reg[31:16];
    end else if (reg_addr == ADDR_EDGE_LOW) begin
      reg_rdata_next = edge_reg[15:0];
    end else if (reg_addr == ADDR_EDGE_HIGH) begin
      reg_rdata_next = edge_reg[31:16];
    end else if (reg_addr == ADDR_IRQ_EN_LOW) begin
      reg_rdata_next = irq_en_reg[15:0];
    end else if (reg_addr == ADDR_IRQ_EN_HIGH) begin
      reg_rdata_next = irq_en_reg[31:16];
    end else if (reg_addr == ADDR_IRQ_FLAG_LOW) begin
      reg_rdata_next = irq_flag_reg[15:0];
    end else if (reg_addr == ADDR_IRQ_FLAG_HIGH) begin
      reg_rdata_next = irq_flag_reg[31:16];
    end else begin
      reg_rdata_next = RDATA_RESET;
    end
  end

  // Read data is registered and holds until the next read.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= RDATA_RESET;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= reg_rdata_next;
    end
  end

endmodule

//--- bench/gpio_pin_model.sv
`timescale 1ns/1ps
module gpio_pin_model
  import gpio_edge_pkg::*;
(
  input  wire logic [PIN_COUNT-1:0] ext_level,
  input  wire logic [PIN_COUNT-1:0] pin_out,
  input  wire logic [PIN_COUNT-1:0] pin_oe_n,
  output      logic [PIN_COUNT-1:0] pin_in
);
  // A driven pin shows the port's own level, an undriven one the outside level.
  always_comb pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

//--- bench/gpio_edge_port_chk.sv
`timescale 1ns/1ps
module gpio_edge_port_chk
  import gpio_edge_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire logic                  clk_en,
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [HALF_WIDTH-1:0] reg_rdata,
  input wire logic [PIN_COUNT-1:0]  pin_in,
  input wire logic [PIN_COUNT-1:0]  pin_out,
  input wire logic [PIN_COUNT-1:0]  pin_oe_n,
  input wire logic                  irq_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic flag_wr = reg_wr && clk_en &&
    (reg_addr == ADDR_IRQ_FLAG_LOW || reg_addr == ADDR_IRQ_FLAG_HIGH);
  sequence s_pin_step;
    $past(pin_in, 3) != $past(pin_in, 4);
  endsequence
  property p_empty_oe; &(pin_oe_n | PIN_IMPL_MASK); endproperty
  property p_hidden; (pin_out & pin_oe_n) == 32'h0000_0000; endproperty
  property p_rst;
    $fell(sys_rst) |-> &pin_oe_n && irq_n && reg_rdata == 16'h0000 && pin_out == 32'h0;
  endproperty
  property p_hold; !irq_n && !flag_wr |=> !irq_n; endproperty
  property p_rose; $rose(irq_n) |-> $past(flag_wr); endproperty
  property p_sync; $fell(irq_n) |-> s_pin_step; endproperty
  property p_empty_rd;
    reg_rd && clk_en && reg_addr == ADDR_IN_HIGH |=> reg_rdata[10:5] == 6'h00;
  endproperty
  property p_unmapped;
    reg_rd && clk_en && reg_addr == 16'h1c12 |=> reg_rdata == 16'h0000;
  endproperty
  a_empty_oe: assert property (p_empty_oe) else $error("empty pin driven");
  a_hidden: assert property (p_hidden) else $error("input pin shows out");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_hold: assert property (p_hold) else $error("request dropped");
  a_rose: assert property (p_rose) else $error("request rose unasked");
  a_sync: assert property (p_sync) else $error("edge latency wrong");
  a_empty_rd: assert property (p_empty_rd) else $error("empty bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule
bind gpio_edge_port gpio_edge_port_chk chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .irq_n(irq_n));

//--- bench/tb_gpio_data_and_edge_interrupts.sv
`timescale 1ns/1ps
module tb_gpio_data_and_edge_interrupts
  import gpio_edge_pkg::*;
;
  logic                  core_clk  = 1'b0;
  logic                  sys_rst   = 1'b1;
  logic                  clk_en    = 1'b1;
  logic [ADDR_WIDTH-1:0] reg_addr  = 16'h0000;
  logic                  reg_wr    = 1'b0;
  logic                  reg_rd    = 1'b0;
  logic [HALF_WIDTH-1:0] reg_wdata = 16'h0000;
  logic [HALF_WIDTH-1:0] reg_rdata;
  logic [PIN_COUNT-1:0]  pin_in;
  logic [PIN_COUNT-1:0]  pin_out;
  logic [PIN_COUNT-1:0]  pin_oe_n;
  logic [PIN_COUNT-1:0]  ext       = 32'h0000_0000;
  logic                  irq_n;
  int                    error_cnt = 0;
  int                    samples_checked = 0;
  initial forever #25 core_clk = ~core_clk;
  gpio_edge_port dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .irq_n(irq_n));
  gpio_pin_model pins (.ext_level(ext), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check({16'h0000, reg_rdata}, {16'h0000, exp});
    @(posedge core_clk);
  endtask
  task automatic port(input logic [31:0] o, input logic [31:0] oe, input logic q);
    @(negedge core_clk);
    check(pin_out, o);
    check(pin_oe_n, oe);
    check({31'h0, irq_n}, {31'h0, q});
    @(posedge core_clk);
  endtask
  task automatic drive(input logic [31:0] v);
    ext <= v;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #(50 * 2000);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int a = 16'h1c06; a <= 16'h1c11; a++) rd(a[15:0], 16'h0000);
    wr(ADDR_OUT_LOW, 16'ha5a5);
    port(32'h0, 32'hffff_ffff, 1'b1);
    rd(ADDR_OUT_LOW, 16'ha5a5);
    wr(ADDR_DIR_LOW, 16'hffff);
    port(32'h0000_a5a5, 32'hffff_0000, 1'b1);
    rd(ADDR_IN_LOW, 16'ha5a5);
    wr(ADDR_OUT_HIGH, 16'hffff);
    wr(ADDR_DIR_HIGH, 16'hffff);
    port(32'hf81f_a5a5, 32'h07e0_0000, 1'b1);
    rd(ADDR_DIR_HIGH, 16'hf81f);
    wr(ADDR_DIR_HIGH, 16'h0000);
    wr(ADDR_DIR_LOW, 16'h0000);
    drive(32'h1234_5678);
    rd(ADDR_IN_LOW, 16'h5678);
    rd(ADDR_IN_HIGH, 16'h1014);
    drive(32'h0);
    wr(ADDR_EDGE_LOW, 16'h000a);
    wr(ADDR_DIR_LOW, 16'h0001);
    wr(ADDR_IRQ_EN_LOW, 16'h000f);
    drive(32'h0000_001f);
    rd(ADDR_IRQ_FLAG_LOW, 16'h0004);
    drive(32'h0);
    rd(ADDR_IRQ_FLAG_LOW, 16'h000e);
    rd(ADDR_IRQ_FLAG_HIGH, 16'h0000);
    wr(ADDR_IRQ_FLAG_LOW, 16'h0000);
    rd(ADDR_IRQ_FLAG_LOW, 16'h000e);
    wr(ADDR_IRQ_FLAG_LOW, 16'h0006);
    port(32'h1, 32'hffff_fffe, 1'b0);
    rd(ADDR_IRQ_FLAG_LOW, 16'h0008);
    wr(ADDR_IRQ_EN_HIGH, 16'hffff);
    wr(ADDR_IRQ_FLAG_LOW, 16'h0008);
    port(32'h1, 32'hffff_fffe, 1'b1);
    drive(32'h07e0_0000);
    drive(32'h8000_0000);
    rd(ADDR_IRQ_FLAG_HIGH, 16'h8000);
    port(32'h1, 32'hffff_fffe, 1'b0);
    rd(16'h1c12, 16'h0000);
    clk_en <= 1'b0;
    wr(ADDR_OUT_LOW, 16'h0000);
    clk_en <= 1'b1;
    rd(ADDR_OUT_LOW, 16'ha5a5);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(ADDR_IRQ_FLAG_HIGH, 16'h0000);
    port(32'h0, 32'hffff_ffff, 1'b1);
    give_verdict();
  end
endmodule
